// ===== inc/dac_channel_control_regs.vh
// Register offsets, field positions, reset values and access timing for the channel control bank
`ifndef DAC_CHANNEL_CONTROL_REGS_VH
`define DAC_CHANNEL_CONTROL_REGS_VH

`define CH2_CONTROL_ADDR 32'h40082408
`define CH3_CONTROL_ADDR 32'h4008240C
`define CH4_CONTROL_ADDR 32'h40082410
`define CH5_CONTROL_ADDR 32'h40082414
`define CH_CONTROL_STRIDE 32'h00000004
`define CH2_DATA_ADDR 32'h4008640C
`define DATA_STRIDE 32'h00000004

`define CTRL_RESET 16'h0100
`define DATA_RESET 32'h00000000
`define CTRL_WRITE_MASK 16'h01FF
`define DATA_WRITE_MASK 32'h0FFF0000

`define POWER_OFF_BIT 8
`define ENABLE_BIT 4
`define RANGE_SELECT_HI 1
`define RANGE_SELECT_LO 0
`define OUTPUT_CODE_HI 27
`define OUTPUT_CODE_LO 16

`define RANGE_INTERNAL_REF 2'h0
`define RANGE_SUPPLY 2'h3

`define CPU_CLOCK_MHZ 80
`define SHORT_ACCESS_CPU_CYCLES 6
`define LONG_ACCESS_CPU_CYCLES 8
`define SYS_CLOCK_MHZ 40
// Link cycles: CPU cycles scaled to the 40 MHz clock, rounded up
`define SHORT_ACCESS_CYCLES ((`SHORT_ACCESS_CPU_CYCLES * `SYS_CLOCK_MHZ + `CPU_CLOCK_MHZ - 1) / `CPU_CLOCK_MHZ)
`define LONG_ACCESS_CYCLES ((`LONG_ACCESS_CPU_CYCLES * `SYS_CLOCK_MHZ + `CPU_CLOCK_MHZ - 1) / `CPU_CLOCK_MHZ)

`endif

// ===== src/dac_channel_slot.v
// One converter channel: control register and data register, returned as zero-padded register words
`timescale 1ns/10ps
`include "dac_channel_control_regs.vh"

module dac_channel_slot (
    input wire clk_i,
    input wire sys_rst_i,
    input wire ctrl_we_i,
    input wire data_we_i,
    input wire [31:0] wdata_i,
    output wire [15:0] ctrl_o,
    output wire [31:0] data_o
);
    localparam [15:0] CTRL_INIT = `CTRL_RESET;

    reg [8:0] ctrl_reg;
    reg [11:0] code_reg;
    wire [15:0] ctrl_next;

    assign ctrl_next = wdata_i[15:0] & `CTRL_WRITE_MASK;

    always @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            ctrl_reg <= CTRL_INIT[8:0];
        end else if (ctrl_we_i) begin
            ctrl_reg <= ctrl_next[8:0]; // RQ1 RQ4 RQ5 RQ6
        end
    end

    // Disable wins over any data write in the same cycle
    always @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            code_reg <= 12'h000;
        end else if (!ctrl_reg[`ENABLE_BIT] || (ctrl_we_i && !ctrl_next[`ENABLE_BIT])) begin
            code_reg <= 12'h000; // RQ2
        end else if (data_we_i) begin
            code_reg <= wdata_i[`OUTPUT_CODE_HI:`OUTPUT_CODE_LO]; // RQ8
        end
    end

    assign ctrl_o = {7'h00, ctrl_reg}; // RQ6
    assign data_o = {4'h0, code_reg, 16'h0000}; // RQ8
endmodule // dac_channel_slot

// ===== src/dac_channel_control_regs.v
// Control and data registers for converter channels 2 to 5 behind the die link
`timescale 1ns/10ps
`include "dac_channel_control_regs.vh"

// Functional notes
// RQ1: Bit 8 powers channel down; resets set
// RQ2: Clearing bit 4 disables, clears channel data
// RQ3: Software sets enable for channel operation
// RQ4: Bits 1:0 select reference or supply range
// RQ5: Range write takes effect immediately
// RQ6: Bits 15:9 read zero; others writable
// RQ7: Independent registers, 4-byte stride, reset 0x0100
// RQ8: Data register code in bits 27:16
// RQ9: Control access takes six processor cycles
// RQ10: Software writes zero to reserved bits
module dac_channel_control_regs #(
    parameter CHANNELS = 4
) (
    input wire clk_i,
    input wire sys_rst_i,
    input wire link_sel_i,
    input wire link_write_i,
    input wire [31:0] link_addr_i,
    input wire [31:0] link_wdata_i,
    output reg [31:0] link_rdata_o,
    output reg link_ready_o,
    output reg link_error_o,
    output reg [CHANNELS-1:0] power_off_o,
    output reg [CHANNELS-1:0] enable_o,
    output reg [2*CHANNELS-1:0] range_select_o,
    output reg [12*CHANNELS-1:0] output_code_o
);
    localparam ST_IDLE = 1'b0;
    localparam ST_WAIT = 1'b1;
    localparam integer SHORT_WAIT_INT = `SHORT_ACCESS_CYCLES;
    localparam integer LONG_WAIT_INT = `LONG_ACCESS_CYCLES;
    localparam [3:0] SHORT_WAIT = SHORT_WAIT_INT[3:0];
    localparam [3:0] LONG_WAIT = LONG_WAIT_INT[3:0];
    localparam [3:0] CTRL_SPACE = 4'h2;
    localparam [31:0] CTRL_BASE = `CH2_CONTROL_ADDR;
    localparam [31:0] CTRL_STEP = `CH_CONTROL_STRIDE;
    localparam [31:0] DATA_BASE = `CH2_DATA_ADDR;
    localparam [31:0] DATA_STEP = `DATA_STRIDE;
    localparam [15:0] CTRL_INIT = `CTRL_RESET;
    localparam [31:0] DATA_INIT = `DATA_RESET;

    reg state_reg;
    reg state_next;
    reg [3:0] count_reg;
    reg [3:0] count_next;
    reg write_reg;
    reg [31:0] addr_reg;
    reg [31:0] wdata_reg;
    reg [15:0] ctrl_rdata;
    reg [31:0] data_rdata;
    reg [31:0] rdata_next;
    wire ctrl_space;
    wire take_req;
    wire last_wait;
    wire do_write;
    wire any_hit;
    wire [CHANNELS-1:0] ctrl_hit;
    wire [CHANNELS-1:0] data_hit;
    wire [16*CHANNELS-1:0] ctrl_bus;
    wire [32*CHANNELS-1:0] data_bus;
    integer k;
    integer m;

    // Narrow control space is faster than the wide data space
    assign ctrl_space = (link_addr_i[15:12] == CTRL_SPACE);
    // A request is only looked at while no access is in flight
    assign take_req = (state_reg == ST_IDLE) && link_sel_i;
    // Access commits on the last wait cycle
    assign last_wait = (state_reg == ST_WAIT) && (count_reg == 4'h1);
    assign do_write = last_wait && write_reg;
    assign any_hit = (|ctrl_hit) || (|data_hit);

    always @* begin
        state_next = state_reg;
        case (state_reg)
            ST_IDLE: begin
                if (link_sel_i) begin
                    state_next = ST_WAIT;
                end
            end
            ST_WAIT: begin
                if (count_reg == 4'h1) begin
                    state_next = ST_IDLE;
                end
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
    end

    always @* begin
        count_next = count_reg;
        case (state_reg)
            ST_IDLE: begin
                if (link_sel_i) begin
                    count_next = ctrl_space ? SHORT_WAIT : LONG_WAIT; // RQ9
                end
            end
            ST_WAIT: begin
                count_next = count_reg - 4'h1;
            end
            default: begin
                count_next = 4'h0;
            end
        endcase
    end

    always @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            state_reg <= ST_IDLE;
            count_reg <= 4'h0;
        end else begin
            state_reg <= state_next;
            count_reg <= count_next;
        end
    end

    // Request fields are latched so the strobe may drop after one cycle
    always @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            write_reg <= 1'b0;
        end else if (take_req) begin
            write_reg <= link_write_i;
        end
    end

    always @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            addr_reg <= 32'h00000000;
        end else if (take_req) begin
            addr_reg <= link_addr_i;
        end
    end

    always @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            wdata_reg <= 32'h00000000;
        end else if (take_req) begin
            wdata_reg <= link_wdata_i;
        end
    end

    always @* begin
        ctrl_rdata = 16'h0000;
        for (k = 0; k < CHANNELS; k = k + 1) begin
            if (ctrl_hit[k]) begin
                ctrl_rdata = ctrl_bus[16*k +: 16];
            end
        end
    end

    always @* begin
        data_rdata = 32'h00000000;
        for (m = 0; m < CHANNELS; m = m + 1) begin
            if (data_hit[m]) begin
                data_rdata = data_bus[32*m +: 32];
            end
        end
    end

    always @* begin
        rdata_next = 32'h00000000;
        // Writes answer with zero read data
        if (!write_reg) begin
            if (|ctrl_hit) begin
                rdata_next = {16'h0000, ctrl_rdata}; // RQ6
            end else if (|data_hit) begin
                rdata_next = data_rdata; // RQ8
            end
        end
    end

    genvar g;
    generate
        for (g = 0; g < CHANNELS; g = g + 1) begin : chan
            wire [31:0] ctrl_addr;
            wire [31:0] data_addr;

            assign ctrl_addr = CTRL_BASE + CTRL_STEP * g; // RQ7
            assign data_addr = DATA_BASE + DATA_STEP * g;
            assign ctrl_hit[g] = (addr_reg == ctrl_addr);
            assign data_hit[g] = (addr_reg == data_addr);

            dac_channel_slot dac_channel_slot_inst (
                .clk_i(clk_i),
                .sys_rst_i(sys_rst_i),
                .ctrl_we_i(do_write && ctrl_hit[g]),
                .data_we_i(do_write && data_hit[g]),
                .wdata_i(wdata_reg),
                .ctrl_o(ctrl_bus[16*g +: 16]),
                .data_o(data_bus[32*g +: 32])
            );

            always @(posedge clk_i or posedge sys_rst_i) begin
                if (sys_rst_i) begin
                    power_off_o[g] <= CTRL_INIT[`POWER_OFF_BIT];
                end else begin
                    power_off_o[g] <= ctrl_bus[16*g + `POWER_OFF_BIT]; // RQ1
                end
            end

            always @(posedge clk_i or posedge sys_rst_i) begin
                if (sys_rst_i) begin
                    enable_o[g] <= CTRL_INIT[`ENABLE_BIT];
                end else begin
                    enable_o[g] <= ctrl_bus[16*g + `ENABLE_BIT]; // RQ2 RQ3
                end
            end

            always @(posedge clk_i or posedge sys_rst_i) begin
                if (sys_rst_i) begin
                    range_select_o[2*g +: 2] <= CTRL_INIT[`RANGE_SELECT_HI:`RANGE_SELECT_LO];
                end else begin
                    range_select_o[2*g +: 2] <= ctrl_bus[16*g + `RANGE_SELECT_LO +: 2]; // RQ4 RQ5
                end
            end

            always @(posedge clk_i or posedge sys_rst_i) begin
                if (sys_rst_i) begin
                    output_code_o[12*g +: 12] <= DATA_INIT[`OUTPUT_CODE_HI:`OUTPUT_CODE_LO];
                end else begin
                    output_code_o[12*g +: 12] <= data_bus[32*g + `OUTPUT_CODE_LO +: 12]; // RQ8
                end
            end
        end
    endgenerate

    always @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            link_ready_o <= 1'b0;
        end else begin
            link_ready_o <= last_wait; // RQ9
        end
    end

    // Error flag and read data hold until the next access completes
    always @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            link_error_o <= 1'b0;
        end else if (last_wait) begin
            link_error_o <= ~any_hit;
        end
    end

    always @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            link_rdata_o <= 32'h00000000;
        end else if (last_wait) begin
            link_rdata_o <= rdata_next;
        end
    end
endmodule // dac_channel_control_regs

// ===== dv/dac_channel_control_regs_checker.sv
// Port assertions for the channel control bank
`timescale 1ns/10ps
module dac_channel_control_regs_checker #(parameter CHANNELS = 4) (
    input wire clk_i,
    input wire sys_rst_i,
    input wire link_sel_i,
    input wire link_write_i,
    input wire [31:0] link_addr_i,
    input wire [31:0] link_wdata_i,
    input wire [31:0] link_rdata_o,
    input wire link_ready_o,
    input wire link_error_o,
    input wire [CHANNELS-1:0] power_off_o,
    input wire [CHANNELS-1:0] enable_o,
    input wire [2*CHANNELS-1:0] range_select_o,
    input wire [12*CHANNELS-1:0] output_code_o
);
    reg bz;
    reg cw;
    reg [31:0] ca;
    reg [31:0] cd;
    wire take = link_sel_i && (!bz || link_ready_o);
    wire hit2 = link_ready_o && cw && ca == 32'h40082408;
    always @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            bz <= 1'b0;
        end else if (take) begin
            bz <= 1'b1;
            cw <= link_write_i;
            ca <= link_addr_i;
            cd <= link_wdata_i;
        end else if (link_ready_o) begin
            bz <= 1'b0;
        end
    end
    default clocking @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);
    a_ctrl_time: assert property (take && link_addr_i[15:12] == 4'h2 |=> !link_ready_o [*3] ##1 link_ready_o)
        else $error("control access latency wrong");
    a_data_time: assert property (take && link_addr_i[15:12] != 4'h2 |=> !link_ready_o [*4] ##1 link_ready_o)
        else $error("data access latency wrong");
    a_ready_pulse: assert property (link_ready_o |=> !link_ready_o)
        else $error("ready longer than one cycle");
    a_ctrl_zero: assert property (link_ready_o && !cw && ca[15:12] == 4'h2 |-> link_rdata_o[31:9] == 23'h0)
        else $error("control upper bits not zero");
    a_data_zero: assert property (link_ready_o && !cw && ca[15:12] == 4'h6 |-> link_rdata_o[31:28] == 4'h0
        && link_rdata_o[15:0] == 16'h0) else $error("data reserved bits not zero");
    a_power_bit: assert property (hit2 |=> power_off_o[0] == $past(cd[8]))
        else $error("power bit not applied");
    a_enable_bit: assert property (hit2 |=> enable_o[0] == $past(cd[4]))
        else $error("enable bit not applied");
    a_range_now: assert property (hit2 |=> range_select_o[1:0] == $past(cd[1:0]))
        else $error("range not applied at once");
    a_code_clear: assert property (!enable_o[0] |-> output_code_o[11:0] == 12'h000)
        else $error("code held while disabled");
endmodule // dac_channel_control_regs_checker
bind dac_channel_control_regs dac_channel_control_regs_checker #(.CHANNELS(CHANNELS)) chk_inst (.clk_i(clk_i),
    .sys_rst_i(sys_rst_i), .link_sel_i(link_sel_i), .link_write_i(link_write_i), .link_addr_i(link_addr_i),
    .link_wdata_i(link_wdata_i), .link_rdata_o(link_rdata_o), .link_ready_o(link_ready_o),
    .link_error_o(link_error_o), .power_off_o(power_off_o), .enable_o(enable_o),
    .range_select_o(range_select_o), .output_code_o(output_code_o));

// ===== dv/dac_channel_control_regs_bench.sv
// Self-checking bench for the channel control bank
`timescale 1ns/10ps
module dac_channel_control_regs_bench;
    logic clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic sel = 1'b0;
    logic wr = 1'b0;
    logic [31:0] ad = 32'h0;
    logic [31:0] wd = 32'h0;
    wire [31:0] rd;
    wire rdy;
    wire err;
    wire [3:0] poff;
    wire [3:0] ens;
    wire [7:0] rng;
    wire [47:0] code;
    int num_errors = 0;
    int n_tests = 0;
    always #12.5 clk_i = ~clk_i;
    dac_channel_control_regs dac_channel_control_regs_inst (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
        .link_sel_i(sel), .link_write_i(wr), .link_addr_i(ad), .link_wdata_i(wd), .link_rdata_o(rd),
        .link_ready_o(rdy), .link_error_o(err), .power_off_o(poff), .enable_o(ens),
        .range_select_o(rng), .output_code_o(code));
    task chk(input string nm, input logic [47:0] ex, input logic [47:0] got);
        n_tests++;
        if (got !== ex) begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", nm, ex, got);
        end
    endtask
    // One access; read data is zero for writes
    task acc(input logic w, input logic [31:0] a, input logic [31:0] d, input logic [31:0] e, input logic er);
        int n;
        @(posedge clk_i);
        sel <= 1'b1;
        wr <= w;
        ad <= a;
        wd <= d;
        @(posedge clk_i);
        sel <= 1'b0;
        n = 0;
        #1;
        while (rdy !== 1'b1 && n < 8) begin
            @(posedge clk_i);
            #1;
            n++;
        end
        chk("ready", 48'h1, {47'h0, rdy});
        chk("rdata", {16'h0, e}, {16'h0, rd});
        chk("error", {47'h0, er}, {47'h0, err});
    endtask
    task t_reset;
        for (int k = 0; k < 4; k++) acc(1'b0, 32'h40082408 + 4 * k, 32'h0, 32'h00000100, 1'b0);
        chk("power_off", 48'hF, {44'h0, poff});
        chk("enable", 48'h0, {44'h0, ens});
        chk("range", 48'h0, {40'h0, rng});
        acc(1'b0, 32'h40082420, 32'h0, 32'h0, 1'b1);
    endtask
    task t_ctrl;
        acc(1'b1, 32'h4008240C, 32'hFFFFFFFF, 32'h0, 1'b0);
        acc(1'b0, 32'h4008240C, 32'h0, 32'h000001FF, 1'b0);
        acc(1'b0, 32'h40082408, 32'h0, 32'h00000100, 1'b0);
        for (int r = 0; r < 4; r++) begin
            acc(1'b1, 32'h40082410, 32'h10 | r, 32'h0, 1'b0);
            @(posedge clk_i);
            #1;
            chk("range4", r, {46'h0, rng[5:4]});
        end
        chk("power_off", 48'hB, {44'h0, poff});
        chk("enable", 48'h6, {44'h0, ens});
    endtask
    task t_data;
        acc(1'b1, 32'h40082408, 32'h00000013, 32'h0, 1'b0);
        acc(1'b1, 32'h4008640C, 32'hFFFFFFFF, 32'h0, 1'b0);
        acc(1'b0, 32'h4008640C, 32'h0, 32'h0FFF0000, 1'b0);
        chk("code", 48'hFFF, {36'h0, code[11:0]});
        chk("range2", 48'h3, {46'h0, rng[1:0]});
        acc(1'b1, 32'h40082408, 32'h00000000, 32'h0, 1'b0);
        @(posedge clk_i);
        #1;
        chk("code", 48'h0, {36'h0, code[11:0]});
        acc(1'b1, 32'h4008640C, 32'h0ABC0000, 32'h0, 1'b0);
        acc(1'b0, 32'h4008640C, 32'h0, 32'h0, 1'b0);
    endtask
    // Reset in mid-run returns every written control field to its reset value
    task t_rerun;
        @(posedge clk_i);
        sys_rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        #1;
        chk("power_off", 48'hF, {44'h0, poff});
        chk("enable", 48'h0, {44'h0, ens});
        chk("range", 48'h0, {40'h0, rng});
        acc(1'b0, 32'h40082410, 32'h0, 32'h00000100, 1'b0);
    endtask
    task finish_test;
        $display("checks %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        #100000;
        num_errors++;
        finish_test;
    end
    initial begin
        repeat (8) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        t_reset;
        t_ctrl;
        t_data;
        t_rerun;
        finish_test;
    end
endmodule // dac_channel_control_regs_bench
